// [atomic_op_pkg.sv]
// constants for the atomic-operation capability and control bits
// assumes a 4 KB configuration space reached by dword-aligned accesses
package atomic_op_pkg;

  // ****************************************
  // function types
  // ****************************************
  typedef enum logic [2:0] {
    FUNC_ENDPOINT,
    FUNC_ROOT_PORT,
    FUNC_SWITCH_UP,
    FUNC_SWITCH_DOWN,
    FUNC_OTHER
  } func_type_t;

  // ****************************************
  // capability structure bases
  // ****************************************
  localparam logic [11:0] PCIE_CAP_BASE = 12'h070;
  localparam logic [11:0] AER_CAP_BASE = 12'h100;
  localparam logic [11:0] ACS_CAP_BASE = 12'h140;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [11:0] CMD_OFFSET = 12'h004;
  localparam logic [11:0] ACS_CTL_OFFSET = 12'h006;
  localparam logic [11:0] DEV_CAP2_OFFSET = 12'h024;
  localparam logic [11:0] DEV_CTL2_OFFSET = 12'h028;
  localparam logic [11:0] UE_STATUS_OFFSET = 12'h004;
  localparam logic [11:0] UE_MASK_OFFSET = 12'h008;
  localparam logic [11:0] UE_SEV_OFFSET = 12'h00c;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BUS_MASTER_BIT = 2;
  localparam int ROUTING_BIT = 6;
  localparam int CPL32_BIT = 7;
  localparam int CPL64_BIT = 8;
  localparam int CAS128_BIT = 9;
  localparam int REQ_EN_BIT = 6;
  localparam int EGRESS_BLOCK_BIT = 7;
  localparam int EGRESS_ERR_BIT = 24;
  localparam int REDIRECT_BIT = 3;

  // ****************************************
  // values after reset
  // ****************************************
  localparam logic BUS_MASTER_RESET = 1'b0;
  localparam logic REQ_EN_RESET = 1'b0;
  localparam logic EGRESS_BLOCK_RESET = 1'b0;
  localparam logic REDIRECT_RESET = 1'b0;
  localparam logic EGRESS_ERR_RESET = 1'b0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [7:0] TAG_RESET = 8'h00;

endpackage : atomic_op_pkg

// [egress_error_log.sv]
// sticky egress-blocked status, mask and severity with error signalling
// assumes hot reset does not reach it; only the power-on reset clears it
`timescale 1ns/1ps
`default_nettype none
module egress_error_log
  import atomic_op_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // events and software writes
  input wire logic blocked,
  input wire logic status_clear,
  input wire logic mask_write,
  input wire logic mask_value,
  input wire logic sev_write,
  input wire logic sev_value,
  // state and messages
  output logic status,
  output logic mask,
  output logic severity,
  output logic err_fatal,
  output logic err_advisory
);
  typedef struct packed {
    logic status;
    logic mask;
    logic severity;
    logic fatal;
    logic advisory;
  } log_state_t;

  log_state_t st, next_st;

  // set wins over a clear in the same cycle
  always_comb begin
    next_st = st;
    if (status_clear) next_st.status = 1'b0;
    if (blocked) next_st.status = 1'b1;
    if (mask_write) next_st.mask = mask_value;
    if (sev_write) next_st.severity = sev_value;
    next_st.fatal = blocked & ~st.mask & st.severity;
    next_st.advisory = blocked & ~st.mask & ~st.severity;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{EGRESS_ERR_RESET, EGRESS_ERR_RESET, EGRESS_ERR_RESET, 1'b0, 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign status = st.status;
  assign mask = st.mask;
  assign severity = st.severity;
  assign err_fatal = st.fatal;
  assign err_advisory = st.advisory;
endmodule : egress_error_log
`default_nettype wire

// [egress_gate.sv]
// egress gate: forwards or blocks atomic requests leaving this port
// assumes one request per cycle, each marked with a tag
`timescale 1ns/1ps
`default_nettype none
module egress_gate
  import atomic_op_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // request in
  input wire logic req_valid,
  input wire logic [7:0] req_tag,
  input wire logic block_en,
  // results
  output logic fwd_valid,
  output logic blocked,
  output logic [7:0] cpl_ur_tag
);
  typedef struct packed {
    logic fwd;
    logic blk;
    logic [7:0] tag;
  } gate_state_t;

  gate_state_t st, next_st;

  // a blocked request is never forwarded, and earns a UR completion
  always_comb begin
    next_st = st;
    next_st.fwd = req_valid & ~block_en;
    next_st.blk = req_valid & block_en;
    if (req_valid & block_en) next_st.tag = req_tag;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{1'b0, 1'b0, TAG_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign fwd_valid = st.fwd;
  assign blocked = st.blk;
  assign cpl_ur_tag = st.tag;
endmodule : egress_gate
`default_nettype wire

// [atomic_op_ctrl.sv]
// atomic-operation capability, control and egress-blocked error logging
// assumes a dword-aligned configuration port and synchronous request strobes
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - routing offered equally on every switch port
// - bus mastering gates memory requests and forwarding
// - routing bit set only for routing ports
// - 32-bit completer bit needs memory space, except on root ports
// - 64-bit completer bit needs memory space, except on root ports
// - 128-bit compare-swap bit needs memory space, except on root ports
// - atomic issue needs requester and bus enables
// - requester enable writable when capable, resets zero
// - requester enable zero outside endpoints, root ports
// - egress blocking writable only on routing ports
// - blocking stops atomic requests leaving here
// - egress-blocked status sticky, write one clears
// - egress-blocked mask sticky read-write, resets zero
// - egress-blocked severity sticky read-write, resets zero
// - redirect strict-order peer completions upstream
// - blocked request logs error, returns UR completion
// - blocked request never sets UR detected
// - non-fatal severity means advisory non-fatal
module atomic_op_ctrl
  import atomic_op_pkg::*;
#(
  parameter func_type_t FUNC_TYPE = FUNC_ENDPOINT,
  parameter logic ROUTING_SUPPORTED = 1'b0,
  parameter logic HAS_MEM_BAR = 1'b1,
  parameter logic CPL32_SUPPORTED = 1'b1,
  parameter logic CPL64_SUPPORTED = 1'b1,
  parameter logic CAS128_SUPPORTED = 1'b0,
  parameter logic REQUESTER_WRITABLE = 1'b1,
  parameter logic REDIRECT_IMPL = 1'b0,
  parameter logic EGRESS_ERR_IMPL = 1'b1
)
(
  // clock and resets
  input wire logic clock,
  input wire logic reset_n,
  input wire logic hot_reset,
  // configuration access
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  // memory and io requests
  input wire logic mem_req_valid,
  output logic mem_req_grant,
  input wire logic upstream_fwd_valid,
  output logic upstream_fwd_grant,
  // atomic requests issued by this function
  input wire logic atomic_req_valid,
  output logic atomic_req_grant,
  output logic atomic_req_refused,
  // atomic requests leaving through this egress port
  input wire logic egress_atomic_valid,
  input wire logic [7:0] egress_atomic_tag,
  output logic egress_atomic_fwd,
  output logic egress_cpl_ur,
  output logic [7:0] egress_cpl_ur_tag,
  output logic err_fatal,
  output logic err_advisory_nonfatal,
  // other unsupported-request events
  input wire logic ur_event,
  input wire logic ur_detected_clear,
  output logic ur_detected,
  // peer-to-peer completions
  input wire logic p2p_cpl_valid,
  input wire logic p2p_cpl_relaxed,
  output logic cpl_redirect_up,
  output logic cpl_route_peer
);

  // ****************************************
  // port type decisions
  // ****************************************

  // a switch builds every port from one parameter set, so routing is uniform
  localparam logic IS_SWITCH = (FUNC_TYPE == FUNC_SWITCH_UP) || (FUNC_TYPE == FUNC_SWITCH_DOWN);
  localparam logic IS_ROOT = (FUNC_TYPE == FUNC_ROOT_PORT);
  localparam logic ROUTE_OK = ROUTING_SUPPORTED & (IS_SWITCH | IS_ROOT);
  localparam logic CPL_OK = HAS_MEM_BAR | IS_ROOT;
  localparam logic REQ_TYPE_OK = (FUNC_TYPE == FUNC_ENDPOINT) || IS_ROOT;
  localparam logic REQ_EN_RW = REQ_TYPE_OK & REQUESTER_WRITABLE;
  localparam logic BLOCK_RW = ROUTE_OK;

  // ****************************************
  // helper functions
  // ****************************************

  // true when the access falls on the dword holding a register
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] reg_addr);
    reg_hit = (addr[11:2] == reg_addr[11:2]);
  endfunction : reg_hit

  // dword bit position of a field, halfword offset included
  function automatic int dword_pos(input logic [11:0] reg_addr, input int bit_pos);
    dword_pos = bit_pos + (reg_addr[1] ? 16 : 0);
  endfunction : dword_pos

  // byte enable covering one bit of the dword
  function automatic logic lane_on(input logic [3:0] be, input int pos);
    lane_on = be[pos / 8];
  endfunction : lane_on

  // ****************************************
  // absolute register addresses
  // ****************************************
  localparam logic [11:0] CMD_ADDR = CMD_OFFSET;
  localparam logic [11:0] ACS_ADDR = ACS_CAP_BASE + ACS_CTL_OFFSET;
  localparam logic [11:0] CAP2_ADDR = PCIE_CAP_BASE + DEV_CAP2_OFFSET;
  localparam logic [11:0] CTL2_ADDR = PCIE_CAP_BASE + DEV_CTL2_OFFSET;
  localparam logic [11:0] UES_ADDR = AER_CAP_BASE + UE_STATUS_OFFSET;
  localparam logic [11:0] UEM_ADDR = AER_CAP_BASE + UE_MASK_OFFSET;
  localparam logic [11:0] UEV_ADDR = AER_CAP_BASE + UE_SEV_OFFSET;

  localparam int BM_POS = dword_pos(CMD_ADDR, BUS_MASTER_BIT);
  localparam int REQ_POS = dword_pos(CTL2_ADDR, REQ_EN_BIT);
  localparam int BLK_POS = dword_pos(CTL2_ADDR, EGRESS_BLOCK_BIT);
  localparam int RDR_POS = dword_pos(ACS_ADDR, REDIRECT_BIT);
  localparam int ERR_POS = dword_pos(UES_ADDR, EGRESS_ERR_BIT);

  // ****************************************
  // capability word
  // ****************************************

  // read-only bits fixed by the build; a bit is zero where the type forbids it
  localparam logic [31:0] CAP2_WORD =
    (32'(ROUTE_OK) << ROUTING_BIT) |
    (32'(CPL_OK & CPL32_SUPPORTED) << CPL32_BIT) |
    (32'(CPL_OK & CPL64_SUPPORTED) << CPL64_BIT) |
    (32'(CPL_OK & CAS128_SUPPORTED) << CAS128_BIT);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic bus_master;
    logic req_en;
    logic egress_block;
    logic redirect_en;
    logic [31:0] rdata;
    logic ack;
    logic mem_grant;
    logic fwd_grant;
    logic atomic_grant;
    logic atomic_refused;
    logic ur_flag;
    logic redirect_up;
    logic route_peer;
  } ctrl_state_t;

  ctrl_state_t st, next_st;

  // ****************************************
  // decode of configuration writes
  // ****************************************
  logic wr_cmd, wr_ctl2, wr_acs, wr_ues, wr_uem, wr_uev;
  logic err_status, err_mask, err_sev;
  logic blocked_evt;

  assign wr_cmd = cfg_req & cfg_we & reg_hit(cfg_addr, CMD_ADDR) & lane_on(cfg_be, BM_POS);
  assign wr_ctl2 = cfg_req & cfg_we & reg_hit(cfg_addr, CTL2_ADDR) & lane_on(cfg_be, REQ_POS);
  assign wr_acs = cfg_req & cfg_we & reg_hit(cfg_addr, ACS_ADDR) & lane_on(cfg_be, RDR_POS);
  assign wr_ues = cfg_req & cfg_we & reg_hit(cfg_addr, UES_ADDR) & lane_on(cfg_be, ERR_POS);
  assign wr_uem = cfg_req & cfg_we & reg_hit(cfg_addr, UEM_ADDR) & lane_on(cfg_be, ERR_POS);
  assign wr_uev = cfg_req & cfg_we & reg_hit(cfg_addr, UEV_ADDR) & lane_on(cfg_be, ERR_POS);

  // ****************************************
  // egress path and error log
  // ****************************************

  // blocking is taken from the register, so a change applies from the next request
  egress_gate u_gate (
    .clock(clock),
    .reset_n(reset_n),
    .req_valid(egress_atomic_valid),
    .req_tag(egress_atomic_tag),
    .block_en(st.egress_block),
    .fwd_valid(egress_atomic_fwd),
    .blocked(blocked_evt),
    .cpl_ur_tag(egress_cpl_ur_tag)
  );

  // sticky bits live apart so that hot reset never touches them
  egress_error_log u_log (
    .clock(clock),
    .reset_n(reset_n),
    .blocked(blocked_evt & EGRESS_ERR_IMPL),
    .status_clear(wr_ues & cfg_wdata[ERR_POS] & EGRESS_ERR_IMPL),
    .mask_write(wr_uem & EGRESS_ERR_IMPL),
    .mask_value(cfg_wdata[ERR_POS]),
    .sev_write(wr_uev & EGRESS_ERR_IMPL),
    .sev_value(cfg_wdata[ERR_POS]),
    .status(err_status),
    .mask(err_mask),
    .severity(err_sev),
    .err_fatal(err_fatal),
    .err_advisory(err_advisory_nonfatal)
  );

  // the completion strobe is the gate's blocked flop itself
  assign egress_cpl_ur = blocked_evt;

  // ****************************************
  // read data
  // ****************************************
  logic [31:0] rd_word;

  // unmapped or unimplemented bits read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (reg_hit(cfg_addr, CMD_ADDR)) begin
      rd_word[BM_POS] = st.bus_master;
    end else if (reg_hit(cfg_addr, CAP2_ADDR)) begin
      rd_word = CAP2_WORD;
    end else if (reg_hit(cfg_addr, CTL2_ADDR)) begin
      rd_word[REQ_POS] = st.req_en;
      rd_word[BLK_POS] = st.egress_block;
    end else if (reg_hit(cfg_addr, ACS_ADDR)) begin
      rd_word[RDR_POS] = st.redirect_en;
    end else if (reg_hit(cfg_addr, UES_ADDR)) begin
      rd_word[ERR_POS] = err_status;
    end else if (reg_hit(cfg_addr, UEM_ADDR)) begin
      rd_word[ERR_POS] = err_mask;
    end else if (reg_hit(cfg_addr, UEV_ADDR)) begin
      rd_word[ERR_POS] = err_sev;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;

    // configuration answer one cycle after the request
    next_st.ack = cfg_req;
    if (cfg_req && !cfg_we) begin
      next_st.rdata = rd_word;
    end

    // control bits; hardwired ones never take a write
    if (wr_cmd) begin
      next_st.bus_master = cfg_wdata[BM_POS];
    end
    if (wr_ctl2 && REQ_EN_RW) begin
      next_st.req_en = cfg_wdata[REQ_POS];
    end
    if (wr_ctl2 && BLOCK_RW && lane_on(cfg_be, BLK_POS)) begin
      next_st.egress_block = cfg_wdata[BLK_POS];
    end
    if (wr_acs && REDIRECT_IMPL) begin
      next_st.redirect_en = cfg_wdata[RDR_POS];
    end

    // memory requests and upstream forwarding need bus mastering
    next_st.mem_grant = mem_req_valid & st.bus_master;
    next_st.fwd_grant = upstream_fwd_valid & st.bus_master & (IS_ROOT | IS_SWITCH);

    // atomic issue needs both enables; the enable is not a capability
    next_st.atomic_grant = atomic_req_valid & st.req_en & st.bus_master;
    next_st.atomic_refused = atomic_req_valid & ~(st.req_en & st.bus_master);

    // only other UR events set the flag; egress blocking is kept out of it
    if (ur_detected_clear) next_st.ur_flag = 1'b0;
    if (ur_event) next_st.ur_flag = 1'b1;

    // strict-order peer completions go upstream when redirect is on
    next_st.redirect_up = p2p_cpl_valid & st.redirect_en & ~p2p_cpl_relaxed;
    next_st.route_peer = p2p_cpl_valid & ~(st.redirect_en & ~p2p_cpl_relaxed);

    // hot reset clears the non-sticky controls and the UR detected flag only
    if (hot_reset) begin
      next_st.bus_master = BUS_MASTER_RESET;
      next_st.req_en = REQ_EN_RESET;
      next_st.egress_block = EGRESS_BLOCK_RESET;
      next_st.redirect_en = REDIRECT_RESET;
      next_st.ur_flag = 1'b0;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st.bus_master <= BUS_MASTER_RESET;
      st.req_en <= REQ_EN_RESET;
      st.egress_block <= EGRESS_BLOCK_RESET;
      st.redirect_en <= REDIRECT_RESET;
      st.rdata <= RDATA_RESET;
      st.ack <= 1'b0;
      st.mem_grant <= 1'b0;
      st.fwd_grant <= 1'b0;
      st.atomic_grant <= 1'b0;
      st.atomic_refused <= 1'b0;
      st.ur_flag <= 1'b0;
      st.redirect_up <= 1'b0;
      st.route_peer <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign cfg_rdata = st.rdata;
  assign cfg_ack = st.ack;
  assign mem_req_grant = st.mem_grant;
  assign upstream_fwd_grant = st.fwd_grant;
  assign atomic_req_grant = st.atomic_grant;
  assign atomic_req_refused = st.atomic_refused;
  assign ur_detected = st.ur_flag;
  assign cpl_redirect_up = st.redirect_up;
  assign cpl_route_peer = st.route_peer;

endmodule : atomic_op_ctrl
`default_nettype wire

// [atomic_op_ctrl_asserts.sv]
// checker: port relations of the atomic-operation control block
// assumes it is bound into atomic_op_ctrl and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module atomic_op_ctrl_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // requests in
  input wire logic cfg_req,
  input wire logic mem_req_valid,
  input wire logic atomic_req_valid,
  input wire logic egress_atomic_valid,
  input wire logic [7:0] egress_atomic_tag,
  input wire logic ur_event,
  input wire logic p2p_cpl_valid,
  input wire logic p2p_cpl_relaxed,
  // results out
  input wire logic cfg_ack,
  input wire logic mem_req_grant,
  input wire logic atomic_req_grant,
  input wire logic atomic_req_refused,
  input wire logic egress_atomic_fwd,
  input wire logic egress_cpl_ur,
  input wire logic [7:0] egress_cpl_ur_tag,
  input wire logic err_fatal,
  input wire logic err_advisory_nonfatal,
  input wire logic ur_detected,
  input wire logic cpl_redirect_up,
  input wire logic cpl_route_peer
);
  // ******
  // assertions
  // ******
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // every access gets its answer one cycle later
  chk_cfg_answer: assert property (cfg_req |=> cfg_ack)
    else $error("config access not answered");
  chk_mem_gate: assert property (mem_req_grant |-> $past(mem_req_valid))
    else $error("memory grant without request");
  chk_atomic_answer: assert property (atomic_req_valid |=> atomic_req_grant != atomic_req_refused)
    else $error("atomic answer not exclusive");
  chk_atomic_cause: assert property ((atomic_req_grant || atomic_req_refused) |-> $past(atomic_req_valid))
    else $error("atomic answer without request");
  chk_egress_outcome: assert property (egress_atomic_valid |=> egress_atomic_fwd != egress_cpl_ur)
    else $error("egress request neither forwarded nor blocked");
  chk_ur_tag_match: assert property (egress_cpl_ur |-> egress_cpl_ur_tag == $past(egress_atomic_tag))
    else $error("wrong ur tag");
  // an error message only follows a blocked request, and only one kind of it
  chk_err_follows: assert property ((err_fatal || err_advisory_nonfatal) |->
    $past(egress_cpl_ur) && !(err_fatal && err_advisory_nonfatal))
    else $error("error without blocked request");
  chk_ur_detect_cause: assert property ($rose(ur_detected) |-> $past(ur_event))
    else $error("ur detected without cause");
  chk_redirect_relaxed: assert property (p2p_cpl_valid && p2p_cpl_relaxed |=> !cpl_redirect_up && cpl_route_peer)
    else $error("relaxed completion redirected");
  chk_redirect_once: assert property (p2p_cpl_valid |=> cpl_redirect_up != cpl_route_peer)
    else $error("completion route not exclusive");

  // main scenarios reached
  cov_blocked: cover property (egress_cpl_ur);
  cov_granted: cover property (atomic_req_grant);
  cov_redirect: cover property (cpl_redirect_up);
endmodule : atomic_op_ctrl_asserts

bind atomic_op_ctrl atomic_op_ctrl_asserts chk (.*);
`default_nettype wire

// [link_partner_model.sv]
// link partner model: sends atomic requests out of the egress port
// assumes the bench raises send just after a falling clock edge
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // bench commands
  input wire logic send,
  input wire logic [7:0] tag_in,
  // toward the egress port
  output logic egress_atomic_valid,
  output logic [7:0] egress_atomic_tag,
  // unsupported-request completions coming back
  input wire logic egress_cpl_ur,
  output logic [7:0] ur_count
);
  logic [7:0] last_tag;
  // between requests the tag shows the inverse of the last one, so a stale tag never matches
  assign egress_atomic_valid = send;
  assign egress_atomic_tag = send ? tag_in : ~last_tag;
  // remember the last tag and count returned completions
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      last_tag <= 8'h00;
      ur_count <= 8'h00;
    end else begin
      if (send) last_tag <= tag_in;
      if (egress_cpl_ur) ur_count <= ur_count + 8'h01;
    end
  end
endmodule : link_partner_model
`default_nettype wire

// [test_atomic_op_ctrl.sv]
// testbench: root port with routing, all completer sizes and redirect
// assumes the config port answers one cycle after each strobe
`timescale 1ns/1ps
`default_nettype none
module test_atomic_op_ctrl
  import atomic_op_pkg::*;
;
  localparam logic [11:0] A_CMD = CMD_OFFSET;
  localparam logic [11:0] A_CAP2 = PCIE_CAP_BASE + DEV_CAP2_OFFSET;
  localparam logic [11:0] A_CTL2 = PCIE_CAP_BASE + DEV_CTL2_OFFSET;
  localparam logic [11:0] A_UES = AER_CAP_BASE + UE_STATUS_OFFSET;
  localparam logic [11:0] A_UEM = AER_CAP_BASE + UE_MASK_OFFSET;
  localparam logic [11:0] A_SEV = AER_CAP_BASE + UE_SEV_OFFSET;
  localparam logic [11:0] A_ACS = ACS_CAP_BASE + ACS_CTL_OFFSET - 12'h002;
  localparam logic [31:0] M_BM = 32'h1 << BUS_MASTER_BIT;
  localparam logic [31:0] M_RE = 32'h1 << REQ_EN_BIT;
  localparam logic [31:0] M_EB = 32'h1 << EGRESS_BLOCK_BIT;
  localparam logic [31:0] M_ERR = 32'h1 << EGRESS_ERR_BIT;
  localparam logic [31:0] M_RD = 32'h1 << (REDIRECT_BIT + 16);
  logic clock, reset_n, hot_reset, cfg_req, cfg_we, cfg_ack, send;
  logic mem_req_valid, mem_req_grant, upstream_fwd_valid, upstream_fwd_grant;
  logic atomic_req_valid, atomic_req_grant, atomic_req_refused, egress_atomic_valid, egress_atomic_fwd;
  logic egress_cpl_ur, err_fatal, err_advisory_nonfatal, ur_event, ur_detected_clear, ur_detected;
  logic p2p_cpl_valid, p2p_cpl_relaxed, cpl_redirect_up, cpl_route_peer;
  logic [3:0] cfg_be;
  logic [11:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, rd;
  logic [7:0] egress_atomic_tag, egress_cpl_ur_tag, tag_in, ur_count;
  int bad_count = 0;
  int comparisons = 0;

  // ******
  // design and far side
  // ******
  atomic_op_ctrl #(.FUNC_TYPE(FUNC_ROOT_PORT), .ROUTING_SUPPORTED(1'b1), .HAS_MEM_BAR(1'b0),
    .CAS128_SUPPORTED(1'b1), .REDIRECT_IMPL(1'b1)) dut (.*);
  link_partner_model partner (.*);

  // 25 MHz clock
  initial clock = 1'b0;
  always #20 clock = ~clock;

  // ******
  // tasks
  // ******
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
    comparisons++;
    if ((got & mask) !== (exp & mask)) begin
      bad_count++;
      $display("mismatch at %0t: value %h, expected %h under %h", $time, got, exp, mask);
    end
  endtask : check_reg
  task automatic check_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s is %b", $time, what, got);
    end
  endtask : check_bit
  // one access; the strobe stands one cycle and the answer is taken a cycle later
  task automatic cfg_access(input logic we, input logic [11:0] addr, input logic [31:0] wd, input logic [3:0] be);
    @(negedge clock);
    {cfg_req, cfg_we, cfg_addr, cfg_wdata, cfg_be} = {1'b1, we, addr, wd, be};
    @(negedge clock);
    cfg_req = 1'b0;
    check_bit(cfg_ack, 1'b1, "config answer");
    rd = cfg_rdata;
  endtask : cfg_access
  task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
    cfg_access(1'b1, addr, wd, 4'hf);
  endtask : wr
  task automatic rd_check(input logic [11:0] addr, input logic [31:0] exp, input logic [31:0] mask);
    cfg_access(1'b0, addr, 32'h0000_0000, 4'h0);
    check_reg(rd, exp, mask);
  endtask : rd_check
  // all request gates at once, strict then relaxed completion
  task automatic gates(input logic bm, input logic re, input logic red);
    for (int r = 0; r < 2; r++) begin
      @(negedge clock);
      {mem_req_valid, upstream_fwd_valid, atomic_req_valid, p2p_cpl_valid, p2p_cpl_relaxed} = {4'hf, r[0]};
      @(negedge clock);
      {mem_req_valid, upstream_fwd_valid, atomic_req_valid, p2p_cpl_valid} = 4'h0;
      check_bit(mem_req_grant, bm, "memory grant");
      check_bit(upstream_fwd_grant, bm, "forward grant");
      check_bit(atomic_req_grant, bm & re, "atomic grant");
      check_bit(atomic_req_refused, !(bm & re), "atomic refusal");
      check_bit(cpl_redirect_up, red & !r[0], "redirect");
    end
  endtask : gates
  // one atomic request at the egress port through the partner
  task automatic egress(input logic [7:0] tag, input logic blk, input logic msk, input logic sev);
    logic [7:0] n;
    n = ur_count;
    @(negedge clock);
    {send, tag_in} = {1'b1, tag};
    @(negedge clock);
    send = 1'b0;
    check_bit(egress_atomic_fwd, !blk, "forwarded");
    check_reg({24'h0, egress_cpl_ur_tag}, {24'h0, tag}, {24'h0, {8{blk}}});
    @(negedge clock);
    check_bit(err_fatal, blk & !msk & sev, "fatal message");
    check_bit(err_advisory_nonfatal, blk & !msk & !sev, "advisory message");
    check_reg({24'h0, ur_count}, {24'h0, n + {7'h0, blk}}, 32'h0000_00ff);
    check_bit(ur_detected, 1'b0, "ur detected");
  endtask : egress
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // watchdog: the tests take about a hundred cycles
  initial begin
    #(40 * 2000);
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done;
  end

  // ******
  // tests
  // ******
  initial begin
    {reset_n, hot_reset, cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata, send, tag_in} = '0;
    {mem_req_valid, upstream_fwd_valid, atomic_req_valid, ur_event, ur_detected_clear} = '0;
    {p2p_cpl_valid, p2p_cpl_relaxed} = '0;
    repeat (10) @(posedge clock);
    @(negedge clock) reset_n = 1'b1;
    rd_check(A_CMD, 32'h0, M_BM);
    rd_check(A_CAP2, 32'h0000_03c0, 32'h0000_03c0);
    rd_check(A_CTL2, 32'h0, M_RE | M_EB);
    rd_check(A_UES, 32'h0, M_ERR);
    rd_check(A_UEM, 32'h0, M_ERR);
    rd_check(A_SEV, 32'h0, M_ERR);
    rd_check(A_ACS, 32'h0, M_RD);
    wr(12'h200, 32'hffff_ffff);
    rd_check(12'h200, 32'h0, 32'hffff_ffff);
    $display("test reset values done");
    gates(1'b0, 1'b0, 1'b0);
    cfg_access(1'b1, A_CMD, 32'hffff_ffff, 4'h0);
    rd_check(A_CMD, 32'h0, M_BM);
    wr(A_CTL2, M_RE);
    gates(1'b0, 1'b1, 1'b0);
    wr(A_CMD, M_BM);
    rd_check(A_CMD, M_BM, M_BM);
    gates(1'b1, 1'b1, 1'b0);
    wr(A_ACS, M_RD);
    rd_check(A_ACS, M_RD, M_RD);
    gates(1'b1, 1'b1, 1'b1);
    $display("test request gates done");
    egress(8'h5a, 1'b0, 1'b0, 1'b0);
    wr(A_CTL2, M_RE | M_EB);
    rd_check(A_CTL2, M_RE | M_EB, M_RE | M_EB);
    egress(8'ha5, 1'b1, 1'b0, 1'b0);
    rd_check(A_UES, M_ERR, M_ERR);
    wr(A_SEV, M_ERR);
    egress(8'h3c, 1'b1, 1'b0, 1'b1);
    wr(A_UEM, M_ERR);
    egress(8'hc3, 1'b1, 1'b1, 1'b1);
    $display("test egress blocking done");
    @(negedge clock) hot_reset = 1'b1;
    @(negedge clock) hot_reset = 1'b0;
    rd_check(A_CMD, 32'h0, M_BM);
    rd_check(A_CTL2, 32'h0, M_RE | M_EB);
    rd_check(A_ACS, 32'h0, M_RD);
    rd_check(A_UEM, M_ERR, M_ERR);
    rd_check(A_SEV, M_ERR, M_ERR);
    wr(A_UES, 32'h0);
    rd_check(A_UES, M_ERR, M_ERR);
    wr(A_UES, M_ERR);
    rd_check(A_UES, 32'h0, M_ERR);
    egress(8'h11, 1'b0, 1'b1, 1'b1);
    $display("test sticky bits done");
    @(negedge clock) ur_event = 1'b1;
    @(negedge clock) ur_event = 1'b0;
    check_bit(ur_detected, 1'b1, "ur detected set");
    ur_detected_clear = 1'b1;
    @(negedge clock) ur_detected_clear = 1'b0;
    check_bit(ur_detected, 1'b0, "ur detected cleared");
    $display("test ur detected done");
    test_done;
  end
endmodule : test_atomic_op_ctrl
`default_nettype wire
